/* File: hw/pcg_pkg.sv */
// package: register map, field positions and timing constants for peripheral clock gating
package pcg_pkg;
   localparam int           PCG_REG_W      = 16;
   localparam int           PCG_ADDR_W     = 4;
   localparam int           PCG_NUM_PERIPH = 16;
   // register offset
   localparam logic [3:0]   PCG_GATE_OFF   = 4'h0;
   localparam logic [3:0]   PCG_STATUS_OFF = 4'h1;
   // reset value of the disable register
   localparam logic [15:0]  PCG_GATE_RST   = 16'h0000;
   // implemented bits of the disable register
   localparam logic [15:0]  PCG_GATE_MASK  = 16'hF9FB;
   // field positions
   localparam int           PCG_TIMER5_BIT = 15;
   localparam int           PCG_TIMER4_BIT = 14;
   localparam int           PCG_TIMER3_BIT = 13;
   localparam int           PCG_TIMER2_BIT = 12;
   localparam int           PCG_TIMER1_BIT = 11;
   localparam int           PCG_DCI_BIT    = 8;
   localparam int           PCG_TWI_BIT    = 7;
   localparam int           PCG_SER2_BIT   = 6;
   localparam int           PCG_SER1_BIT   = 5;
   localparam int           PCG_SPI2_BIT   = 4;
   localparam int           PCG_SPI1_BIT   = 3;
   localparam int           PCG_CAN_BIT    = 1;
   localparam int           PCG_ADC_BIT    = 0;
   // one instruction cycle in system clocks
   localparam int           PCG_INSN_CLKS  = 2;
   localparam logic [15:0]  PCG_ZERO16     = 16'h0000;
endpackage : pcg_pkg

/* File: hw/pcg_insn_tick.sv */
// instruction-cycle enable divider
`timescale 1ns/1ns
`default_nettype none
module pcg_insn_tick
   import pcg_pkg::*;
#(
   parameter int DIV = PCG_INSN_CLKS
) (
   // clock and reset
   input  wire logic clock,
   input  wire logic resetn,
   // one-cycle enable at the instruction rate
   output var  logic tick
);
   // refuse divisions that the eight-bit counter cannot hold
   if (DIV < 1 || DIV > 256) begin : g_div_check
      $error("pcg_insn_tick: DIV out of range");
   end

   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   logic       tick_r;
   logic       tick_nxt;

   localparam logic [7:0] LAST = 8'(DIV - 1);

   // count system clocks, pulse on the last one
   always_comb begin
      tick_nxt = (cnt_r == LAST);
      cnt_nxt  = tick_nxt ? 8'h00 : cnt_r + 8'h01;
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         cnt_r  <= 8'h00;
         tick_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tick = tick_r;
endmodule : pcg_insn_tick
`default_nettype wire

/* File: hw/pcg_gate.sv */
// peripheral clock gating: disable register, delayed enables, access gating
// How it works
// - a set disable bit gates off every clock enable of that peripheral
// - a disabled peripheral is held in reset-like lowest power while bit is set
// - while disabled, peripheral register writes are blocked; reads return zero only while every peripheral is disabled
// - enable only when disable bit clear and peripheral present on variant
// - after reset all implemented disable bits read zero, peripherals enabled
// - setting a bit disables its module at the next instruction boundary, within one instruction cycle
// - clearing a bit re-enables its module at the next instruction boundary, within one instruction cycle
`timescale 1ns/1ns
`default_nettype none
module pcg_gate
   import pcg_pkg::*;
#(
   parameter logic [15:0] PRESENT = 16'hFFFF  // peripherals built on this variant
) (
   // clock and reset
   input  wire logic                  clock,
   input  wire logic                  resetn,
   // register port
   input  wire logic [PCG_ADDR_W-1:0] addr,
   input  wire logic [PCG_REG_W-1:0]  wdata,
   input  wire logic                  wr,
   input  wire logic                  rd,
   output var  logic [PCG_REG_W-1:0]  rdata,
   // peripheral register access gating
   input  wire logic [15:0]           periph_wr,
   input  wire logic [15:0]           periph_rdata_in,
   output var  logic [15:0]           periph_wr_ok,
   output var  logic [15:0]           periph_rdata_ok,
   // peripheral clocks and low-power hold
   output var  logic [15:0]           clk_en,
   output var  logic [15:0]           periph_hold
);
   logic [15:0] gate_r, gate_nxt;       // module_clock_gate_reg
   logic [15:0] run_r, run_nxt;
   logic [15:0] clken_r, clken_nxt;
   logic [15:0] hold_r, hold_nxt;
   logic [15:0] wok_r, wok_nxt;
   logic [15:0] rok_r, rok_nxt;
   logic [15:0] rdata_r, rdata_nxt;
   logic        tick;

   // the lane ports are sixteen bits wide and the divider needs a count of one or more
   if (PCG_REG_W != 16 || PCG_NUM_PERIPH != 16 || PCG_INSN_CLKS < 1) begin : g_cfg_check
      $error("pcg_gate: package constants do not fit the sixteen-lane ports");
   end

   // named field views of the disable register
   logic timer5_off, timer4_off, timer3_off, timer2_off, timer1_off, data_conv_if_off;
   logic two_wire_bus_off, serial_port2_off, serial_port1_off, spi_second_off;
   logic spi_first_off, can_module_off, analog_conv_off;
   assign timer5_off       = gate_r[PCG_TIMER5_BIT];
   assign timer4_off       = gate_r[PCG_TIMER4_BIT];
   assign timer3_off       = gate_r[PCG_TIMER3_BIT];
   assign timer2_off       = gate_r[PCG_TIMER2_BIT];
   assign timer1_off       = gate_r[PCG_TIMER1_BIT];
   assign data_conv_if_off = gate_r[PCG_DCI_BIT];
   assign two_wire_bus_off = gate_r[PCG_TWI_BIT];
   assign serial_port2_off = gate_r[PCG_SER2_BIT];
   assign serial_port1_off = gate_r[PCG_SER1_BIT];
   assign spi_second_off   = gate_r[PCG_SPI2_BIT];
   assign spi_first_off    = gate_r[PCG_SPI1_BIT];
   assign can_module_off   = gate_r[PCG_CAN_BIT];
   assign analog_conv_off  = gate_r[PCG_ADC_BIT];

   function automatic logic [15:0] impl(input logic [15:0] v);
      impl = v & PCG_GATE_MASK & PRESENT;
   endfunction : impl

   // instruction-cycle enable
   pcg_insn_tick #(.DIV(PCG_INSN_CLKS)) u_tick (
      .clock  (clock),
      .resetn (resetn),
      .tick   (tick)
   );

   // disable register: software writes, unimplemented and absent bits forced low
   always_comb begin
      gate_nxt = gate_r;
      if (wr && addr == PCG_GATE_OFF) begin
         gate_nxt = impl(wdata);
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         gate_r <= PCG_GATE_RST;
      end else begin
         gate_r <= gate_nxt;
      end
   end

   // run state follows the register only at instruction boundaries
   always_comb begin
      run_nxt = run_r;
      if (tick) begin
         run_nxt = impl(PCG_GATE_MASK) & ~gate_r;
      end
      clken_nxt = run_nxt;
      hold_nxt  = ~run_nxt;
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         run_r   <= PCG_GATE_MASK & PRESENT;
         clken_r <= PCG_GATE_MASK & PRESENT;
         hold_r  <= ~(PCG_GATE_MASK & PRESENT);
      end else begin
         run_r   <= run_nxt;
         clken_r <= clken_nxt;
         hold_r  <= hold_nxt;
      end
   end

   // peripheral register writes pass only while the peripheral runs, reads while any peripheral runs
   always_comb begin
      wok_nxt = periph_wr & run_nxt;
      rok_nxt = run_r == PCG_ZERO16 ? PCG_ZERO16 : periph_rdata_in;
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         wok_r <= PCG_ZERO16;
         rok_r <= PCG_ZERO16;
      end else begin
         wok_r <= wok_nxt;
         rok_r <= rok_nxt;
      end
   end

   // read mux: data stand one cycle after the strobe, zero otherwise
   always_comb begin
      rdata_nxt = PCG_ZERO16;
      if (rd) begin
         unique case (addr)
            PCG_GATE_OFF:   rdata_nxt = gate_r;
            PCG_STATUS_OFF: rdata_nxt = run_r;
            default:        rdata_nxt = PCG_ZERO16;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         rdata_r <= PCG_ZERO16;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign rdata           = rdata_r;
   assign clk_en          = clken_r;
   assign periph_hold     = hold_r;
   assign periph_wr_ok    = wok_r;
   assign periph_rdata_ok = rok_r;

   // reset, map and gating checks
   reset_value_a: assert property (
      @(posedge clock) $rose(resetn) |-> gate_r == PCG_ZERO16)
      else $error("disable register not zero after reset");
   clk_off_a: assert property (
      @(posedge clock) disable iff (!resetn)
      (clk_en & ~(PCG_GATE_MASK & PRESENT)) == PCG_ZERO16)
      else $error("clock enabled for absent peripheral");
   hold_match_a: assert property (
      @(posedge clock) disable iff (!resetn) periph_hold == ~clk_en)
      else $error("hold and clock disagree");
   off_delay_a: assert property (
      @(posedge clock) disable iff (!resetn)
      tick && gate_r[PCG_ADC_BIT] && PRESENT[PCG_ADC_BIT] |=> ##1 !clk_en[PCG_ADC_BIT])
      else $error("adc clock not off one instruction later");
   on_delay_a: assert property (
      @(posedge clock) disable iff (!resetn)
      tick && !gate_r[PCG_ADC_BIT] && PRESENT[PCG_ADC_BIT] |=> ##1 clk_en[PCG_ADC_BIT])
      else $error("adc clock not on one instruction later");
   wr_block_a: assert property (
      @(posedge clock) disable iff (!resetn) (periph_wr_ok & ~clk_en) == PCG_ZERO16)
      else $error("write passed to disabled peripheral");
   unused_zero_a: assert property (
      @(posedge clock) disable iff (!resetn) (gate_r & ~PCG_GATE_MASK) == PCG_ZERO16)
      else $error("unused bit set");
   read_hide_a: assert property (
      @(posedge clock) disable iff (!resetn)
      $past(clk_en) == PCG_ZERO16 |-> periph_rdata_ok == PCG_ZERO16)
      else $error("read data passed while every peripheral is off");
   change_on_tick_a: assert property (
      @(posedge clock) disable iff (!resetn) $changed(clk_en) |-> $past(tick))
      else $error("clock enable changed between instruction boundaries");

   // register port checks
   read_back_a: assert property (
      @(posedge clock) disable iff (!resetn)
      rd && addr == PCG_GATE_OFF |=> rdata == $past(gate_r))
      else $error("register read mismatch");
   status_read_a: assert property (
      @(posedge clock) disable iff (!resetn)
      rd && addr == PCG_STATUS_OFF |=> rdata == $past(clk_en))
      else $error("status read does not show the running peripherals");
   idle_rdata_a: assert property (
      @(posedge clock) disable iff (!resetn) !rd |=> rdata == PCG_ZERO16)
      else $error("read data not zero without a read");
   write_lands_a: assert property (
      @(posedge clock) disable iff (!resetn)
      wr && addr == PCG_GATE_OFF |=> gate_r == ($past(wdata) & PCG_GATE_MASK & PRESENT))
      else $error("register write did not land");
   wr_other_a: assert property (
      @(posedge clock) disable iff (!resetn)
      !(wr && addr == PCG_GATE_OFF) |=> $stable(gate_r))
      else $error("disable register changed without a write");

   // every present peripheral follows its own bit at the next instruction boundary
   for (genvar b = 0; b < PCG_NUM_PERIPH; b++) begin : g_bit_chk
      if (PCG_GATE_MASK[b] && PRESENT[b]) begin : g_impl
         bit_off_a: assert property (
            @(posedge clock) disable iff (!resetn) tick && gate_r[b] |=> !clk_en[b])
            else $error("clock not off at the instruction boundary");
         bit_on_a: assert property (
            @(posedge clock) disable iff (!resetn) tick && !gate_r[b] |=> clk_en[b])
            else $error("clock not on at the instruction boundary");
      end
   end

   // main scenarios
   cov_off_c: cover property (@(posedge clock) $fell(clk_en[PCG_TIMER1_BIT]));
   cov_on_c:  cover property (@(posedge clock) $rose(clk_en[PCG_TIMER1_BIT]));
   cov_rd_c:  cover property (@(posedge clock) rd && addr == PCG_STATUS_OFF);
   cov_all_off_c: cover property (@(posedge clock) timer5_off && timer4_off
      && timer3_off && timer2_off && timer1_off && data_conv_if_off
      && two_wire_bus_off && serial_port2_off && serial_port1_off && spi_second_off
      && spi_first_off && can_module_off && analog_conv_off);
endmodule : pcg_gate
`default_nettype wire

/* File: verification/peripheral_clock_gating_tb.sv */
// testbench for peripheral clock gating: register access, gate latency, access blocking
`timescale 1ns/1ns
`default_nettype none
module peripheral_clock_gating_tb;
   import pcg_pkg::*;
   logic        clock;
   logic        resetn;
   logic [3:0]  addr;
   logic [15:0] wdata;
   logic        wr;
   logic        rd;
   logic [15:0] rdata;
   logic [15:0] periph_wr;
   logic [15:0] periph_rdata_in;
   logic [15:0] periph_wr_ok;
   logic [15:0] periph_rdata_ok;
   logic [15:0] clk_en;
   logic [15:0] periph_hold;
   logic [15:0] run_exp;
   int          miscompares;
   int          samples_checked;

   pcg_gate i_dut (.clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .periph_wr(periph_wr), .periph_rdata_in(periph_rdata_in),
      .periph_wr_ok(periph_wr_ok), .periph_rdata_ok(periph_rdata_ok), .clk_en(clk_en),
      .periph_hold(periph_hold));

   // 125 MHz clock
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   // compare one 16-bit result and count it
   task chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // register write: one strobe cycle
   task wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clock);
      wr    <= 1'b0;
   endtask : wr_reg

   // register read: data stands the cycle after the strobe
   task rd_reg(input logic [3:0] a, input logic [15:0] e);
      @(posedge clock);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clock);
      rd   <= 1'b0;
      #1 chk(rdata, e);
   endtask : rd_reg

   // write the disable register: old enables stand right after the write,
   // new ones after the next instruction boundary, two clocks on at the latest
   task gate_set(input logic [15:0] d);
      wr_reg(PCG_GATE_OFF, d);
      #1 chk(clk_en, run_exp);
      run_exp = PCG_GATE_MASK & ~d;
      repeat (2) @(posedge clock);
      #1 chk(clk_en, run_exp);
      chk(periph_hold, ~run_exp);
   endtask : gate_set

   // verdict and end of run
   task end_sim;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_sim

   // watchdog against a hang
   initial begin
      repeat (3000) @(posedge clock);
      miscompares++;
      end_sim();
   end

   // main sequence
   initial begin
      miscompares = 0;
      samples_checked = 0;
      resetn = 1'b0;
      addr = 4'h0;
      wdata = 16'h0000;
      wr = 1'b0;
      rd = 1'b0;
      periph_wr = 16'h0000;
      periph_rdata_in = 16'h0000;
      run_exp = PCG_GATE_MASK;
      repeat (6) @(posedge clock);
      resetn <= 1'b1;
      #1 chk(clk_en, PCG_GATE_MASK);
      chk(periph_hold, ~PCG_GATE_MASK);
      rd_reg(PCG_GATE_OFF, 16'h0000);
      rd_reg(PCG_STATUS_OFF, PCG_GATE_MASK);
      $display("test reset done");
      for (int i = 0; i < 16; i++) begin
         gate_set(16'h0001 << i);
         rd_reg(PCG_GATE_OFF, PCG_GATE_MASK & (16'h0001 << i));
      end
      $display("test bit map done");
      gate_set(16'hFFFF);
      @(posedge clock);
      periph_wr <= 16'hFFFF;
      periph_rdata_in <= 16'hA5A5;
      repeat (2) @(posedge clock);
      #1 chk(periph_wr_ok, 16'h0000);
      chk(periph_rdata_ok, 16'h0000);
      gate_set(16'hFFFE);
      @(posedge clock);
      #1 chk(periph_wr_ok, 16'h0001);
      chk(periph_rdata_ok, 16'hA5A5);
      $display("test access blocking done");
      wr_reg(4'hF, 16'h0000);
      wr_reg(PCG_STATUS_OFF, 16'h0000);
      rd_reg(4'hF, 16'h0000);
      rd_reg(PCG_GATE_OFF, 16'hF9FA);
      rd_reg(PCG_STATUS_OFF, 16'h0001);
      $display("test unmapped done");
      @(posedge clock);
      resetn <= 1'b0;
      repeat (2) @(posedge clock);
      resetn <= 1'b1;
      rd_reg(PCG_GATE_OFF, 16'h0000);
      chk(clk_en, PCG_GATE_MASK);
      $display("test second reset done");
      end_sim();
   end
endmodule : peripheral_clock_gating_tb
`default_nettype wire
